// [cbi_consts.svh]
// Constants for the card bridge interrupt and socket pin block.
// Summary of operation
// - Socket interrupt line asserts when the socket function has a selected pending interrupt.
// - Serial bus interrupt line asserts for serial bus link function interrupts.
// - Flash media interrupt line asserts when any of three flash functions requests.
// - Each of six user pins takes a function chosen by a control register field.
// - With a card inserted, the I/O card and ring enable bits set and wake mode off, card ring input goes to ring output.
// - Ring/wake output becomes wake event when wake enable set or power state not D0.
// - Card data input buffers are disabled when socket power is off or no card.
// - Attribute select is low for attribute memory, high for common memory.
// - Ready/interrupt input means ready/busy for memory cards, interrupt for I/O cards.
// - Protect/width input means write protect for memory cards, 16-bit port for I/O.
// - A 26-bit card address bus and 16-bit two-way card data bus serve socket cycles.
// - Card insertion comes from both card-detect inputs being low.
`ifndef CBI_CONSTS_SVH
`define CBI_CONSTS_SVH
`define CBI_ADDR_W 4
`define CBI_OFF_CTRL 4'h0
`define CBI_OFF_PINFN 4'h1
`define CBI_OFF_GPIO_OUT 4'h2
`define CBI_OFF_GPIO_IN 4'h3
`define CBI_OFF_STATUS 4'h4
`define CBI_OFF_MASK 4'h5
`define CBI_OFF_PINS 4'h6
`define CBI_CTRL_SRC_LSB 0
`define CBI_CTRL_RING_EN 2
`define CBI_CTRL_WAKE_EN 3
`define CBI_CTRL_PSTATE_LSB 4
`define CBI_CTRL_SOCK_PWR 6
`define CBI_CTRL_IO_CARD 7
`define CBI_CTRL_ATTR 8
`define CBI_CTRL_RESET 32'h00000000
`define CBI_PINFN_RESET 32'h00000000
`define CBI_ST_W 5
`define CBI_ST_SOCK 0
`define CBI_ST_SBUS 1
`define CBI_ST_FLASH 2
`define CBI_ST_CARD 3
`define CBI_ST_WAKE 4
`define CBI_NPINS 6
`endif

// [cbi_pkg.sv]
// Types for the card bridge interrupt and socket pin block.
package cbi_pkg;
	// Function of one user pin.
	typedef enum logic [1:0] {
		CBI_FN_GPIN = 2'h0,
		CBI_FN_GPOUT = 2'h1,
		CBI_FN_IND = 2'h2,
		CBI_FN_SIRQ = 2'h3
	} cbi_pinfn_e;
	// Function of the shared ring/wake pin.
	typedef enum logic [2:0] {
		CBI_RW_IDLE = 3'h1,
		CBI_RW_RING = 3'h2,
		CBI_RW_WAKE = 3'h4
	} cbi_rw_e;
	// Register bus request.
	typedef struct packed {
		logic [3:0] addr;
		logic [31:0] wdata;
		logic wr;
		logic rd;
	} cbi_bus_s;
	// Decoded dual-function card inputs.
	typedef struct packed {
		logic ready;
		logic card_irq;
		logic write_protect;
		logic wide_port;
	} cbi_card_s;
endpackage : cbi_pkg

// [cbi_top.sv]
// Interrupt routing, ring/wake pin, user pins and socket signal gating.
//
// Implementation choices: strobed register access and the placing of the registers.
`timescale 1ns/1ps
`include "cbi_consts.svh"
module cbi_top
	import cbi_pkg::*;
#(
	parameter int NPINS = `CBI_NPINS
) (
	input wire logic clk_in,
	input wire logic srst_in,
	input wire cbi_bus_s bus_in,
	output logic [31:0] rdata_out,
	input wire logic sock_evt_in,
	input wire logic sbus_evt_in,
	input wire logic [2:0] flash_evt_in,
	input wire logic card_detect_first_n_in,
	input wire logic card_detect_second_n_in,
	input wire logic status_change_n_in,
	input wire logic card_irq_n_in,
	input wire logic wide_io_port_n_in,
	input wire logic mem_cycle_in,
	input wire logic [25:0] cyc_addr_in,
	input wire logic [15:0] cyc_wdata_in,
	input wire logic cyc_write_in,
	output logic [25:0] card_address_bus_out,
	input wire logic [15:0] card_data_bus_in,
	output logic [15:0] card_data_bus_out,
	output logic card_data_bus_oe_out,
	output logic [15:0] card_rdata_out,
	output logic attr_select_n_out,
	output logic card_present_out,
	output cbi_card_s card_out,
	output logic socket_irq_line_out,
	output logic socket_irq_line_oe_out,
	output logic serial_bus_irq_line_out,
	output logic serial_bus_irq_line_oe_out,
	output logic flash_media_irq_line_out,
	output logic flash_media_irq_line_oe_out,
	output logic ring_forward_out,
	output logic ring_forward_oe_out,
	output logic irq_out,
	input wire logic [NPINS-1:0] user_pin_in,
	output logic [NPINS-1:0] user_pin_out,
	output logic [NPINS-1:0] user_pin_oe_out
);
	logic [31:0] ctrl_q;
	logic [2*NPINS-1:0] pinfn_q;
	logic [NPINS-1:0] gpo_q;
	logic [`CBI_ST_W-1:0] status_q;
	logic [`CBI_ST_W-1:0] mask_q;
	logic [`CBI_ST_W-1:0] evt_d;
	logic [NPINS-1:0] upin_s1_q;
	logic [NPINS-1:0] upin_s2_q;
	logic [7:0] card_s1_q;
	logic [7:0] card_s2_q;
	logic card_in_q;
	logic ring_q;
	logic sock_req;
	logic flash_req;
	logic wake_mode;
	logic ring_mode;
	cbi_rw_e rw_q;
	cbi_card_s card_d;

	// Two-flop synchronisers for the user pins and the card status pins; card data is not synchronised.
	always_ff @(posedge clk_in) begin
		if (srst_in) begin
			upin_s1_q <= '0;
			upin_s2_q <= '0;
			card_s1_q <= 8'hFF;
			card_s2_q <= 8'hFF;
		end else begin
			upin_s1_q <= user_pin_in;
			upin_s2_q <= upin_s1_q;
			card_s1_q <= {3'h7, wide_io_port_n_in, card_irq_n_in, status_change_n_in,
				card_detect_second_n_in, card_detect_first_n_in};
			card_s2_q <= card_s1_q;
		end
	end

	// Card is in only while both detect pins are low.
	always_ff @(posedge clk_in) begin
		if (srst_in) begin
			card_in_q <= 1'b0;
		end else begin
			card_in_q <= ~card_s2_q[0] & ~card_s2_q[1];
		end
	end

	// Dual-function inputs decoded by card type.
	always_comb begin
		card_d = '0;
		if (ctrl_q[`CBI_CTRL_IO_CARD]) begin
			card_d.card_irq = ~card_s2_q[3];
			card_d.wide_port = ~card_s2_q[4];
		end else begin
			card_d.ready = card_s2_q[3];
			card_d.write_protect = card_s2_q[4];
		end
	end

	// Socket request source: 0 host event, 1 card interrupt, 2 either, 3 card change.
	always_comb begin
		unique case (ctrl_q[`CBI_CTRL_SRC_LSB +: 2])
			2'h0: sock_req = sock_evt_in;
			2'h1: sock_req = card_d.card_irq & card_in_q;
			2'h2: sock_req = sock_evt_in | (card_d.card_irq & card_in_q);
			2'h3: sock_req = status_q[`CBI_ST_CARD];
		endcase
	end

	assign flash_req = |flash_evt_in;
	assign wake_mode = ctrl_q[`CBI_CTRL_WAKE_EN] | (ctrl_q[`CBI_CTRL_PSTATE_LSB +: 2] != 2'h0);
	assign ring_mode = card_in_q & ctrl_q[`CBI_CTRL_RING_EN] & ctrl_q[`CBI_CTRL_IO_CARD];

	// Sticky event sources.
	always_comb begin
		evt_d = '0;
		evt_d[`CBI_ST_SOCK] = sock_req;
		evt_d[`CBI_ST_SBUS] = sbus_evt_in;
		evt_d[`CBI_ST_FLASH] = flash_req;
		// One-cycle pulse when the synchronised detect pins disagree with the stored presence.
		evt_d[`CBI_ST_CARD] = card_in_q != (~card_s2_q[0] & ~card_s2_q[1]);
		evt_d[`CBI_ST_WAKE] = wake_mode & ring_q;
	end

	// Control registers written by software.
	always_ff @(posedge clk_in) begin
		if (srst_in) begin
			ctrl_q <= `CBI_CTRL_RESET;
			pinfn_q <= '0;
			gpo_q <= '0;
			mask_q <= '0;
		end else if (bus_in.wr) begin
			if (bus_in.addr == `CBI_OFF_CTRL) begin
				ctrl_q <= bus_in.wdata;
			end
			if (bus_in.addr == `CBI_OFF_PINFN) begin
				pinfn_q <= bus_in.wdata[2*NPINS-1:0];
			end
			if (bus_in.addr == `CBI_OFF_GPIO_OUT) begin
				gpo_q <= bus_in.wdata[NPINS-1:0];
			end
			if (bus_in.addr == `CBI_OFF_MASK) begin
				mask_q <= bus_in.wdata[`CBI_ST_W-1:0];
			end
		end
	end

	// Status bits: set wins over a write-one clear.
	always_ff @(posedge clk_in) begin
		if (srst_in) begin
			status_q <= '0;
		end else if (bus_in.wr && bus_in.addr == `CBI_OFF_STATUS) begin
			status_q <= (status_q & ~bus_in.wdata[`CBI_ST_W-1:0]) | evt_d;
		end else begin
			status_q <= status_q | evt_d;
		end
	end

	// Read data, valid the cycle after the read strobe.
	always_ff @(posedge clk_in) begin
		if (srst_in) begin
			rdata_out <= '0;
		end else if (bus_in.rd) begin
			unique case (bus_in.addr)
				`CBI_OFF_CTRL: rdata_out <= ctrl_q;
				`CBI_OFF_PINFN: rdata_out <= 32'(pinfn_q);
				`CBI_OFF_GPIO_OUT: rdata_out <= 32'(gpo_q);
				`CBI_OFF_GPIO_IN: rdata_out <= 32'(upin_s2_q);
				`CBI_OFF_STATUS: rdata_out <= 32'(status_q);
				`CBI_OFF_MASK: rdata_out <= 32'(mask_q);
				`CBI_OFF_PINS: rdata_out <= {25'h0, card_in_q, 2'(rw_q >> 1), card_d};
				default: rdata_out <= '0;
			endcase
		end else begin
			rdata_out <= '0;
		end
	end

	// Interrupt request lines pull low only while asserted.
	always_ff @(posedge clk_in) begin
		if (srst_in) begin
			socket_irq_line_oe_out <= 1'b0;
			serial_bus_irq_line_oe_out <= 1'b0;
			flash_media_irq_line_oe_out <= 1'b0;
			irq_out <= 1'b0;
		end else begin
			socket_irq_line_oe_out <= sock_req;
			serial_bus_irq_line_oe_out <= sbus_evt_in;
			flash_media_irq_line_oe_out <= flash_req;
			irq_out <= |(status_q & mask_q);
		end
	end

	// Open-drain drive levels are always low.
	always_ff @(posedge clk_in) begin
		if (srst_in) begin
			socket_irq_line_out <= 1'b0;
			serial_bus_irq_line_out <= 1'b0;
			flash_media_irq_line_out <= 1'b0;
			ring_forward_out <= 1'b0;
		end else begin
			socket_irq_line_out <= 1'b0;
			serial_bus_irq_line_out <= 1'b0;
			flash_media_irq_line_out <= 1'b0;
			ring_forward_out <= 1'b0;
		end
	end

	// Ring request seen on the shared status-change pin.
	always_ff @(posedge clk_in) begin
		if (srst_in) begin
			ring_q <= 1'b0;
		end else begin
			ring_q <= card_in_q & ~card_s2_q[2];
		end
	end

	// Ring/wake pin mode selection.
	always_ff @(posedge clk_in) begin
		if (srst_in) begin
			rw_q <= CBI_RW_IDLE;
		end else if (wake_mode) begin
			rw_q <= CBI_RW_WAKE;
		end else if (ring_mode) begin
			rw_q <= CBI_RW_RING;
		end else begin
			rw_q <= CBI_RW_IDLE;
		end
	end

	// Ring/wake pin drive.
	always_ff @(posedge clk_in) begin
		if (srst_in) begin
			ring_forward_oe_out <= 1'b0;
		end else begin
			unique case (rw_q)
				CBI_RW_RING: ring_forward_oe_out <= ring_q;
				CBI_RW_WAKE: ring_forward_oe_out <= status_q[`CBI_ST_WAKE];
				CBI_RW_IDLE: ring_forward_oe_out <= 1'b0;
				default: ring_forward_oe_out <= 1'b0;
			endcase
		end
	end

	// Per-pin user function.
	genvar gi;
	generate
		for (gi = 0; gi < NPINS; gi++) begin : g_pin
			always_ff @(posedge clk_in) begin
				if (srst_in) begin
					user_pin_out[gi] <= 1'b0;
					user_pin_oe_out[gi] <= 1'b0;
				end else begin
					unique case (cbi_pinfn_e'(pinfn_q[2*gi +: 2]))
						CBI_FN_GPIN: begin
							user_pin_out[gi] <= 1'b0;
							user_pin_oe_out[gi] <= 1'b0;
						end
						CBI_FN_GPOUT: begin
							user_pin_out[gi] <= gpo_q[gi];
							user_pin_oe_out[gi] <= 1'b1;
						end
						CBI_FN_IND: begin
							user_pin_out[gi] <= ~gpo_q[gi];
							user_pin_oe_out[gi] <= 1'b1;
						end
						CBI_FN_SIRQ: begin
							user_pin_out[gi] <= ~irq_out;
							user_pin_oe_out[gi] <= 1'b1;
						end
					endcase
				end
			end
		end
	endgenerate

	// Socket cycle pins and input buffer gating.
	always_ff @(posedge clk_in) begin
		if (srst_in) begin
			card_address_bus_out <= '0;
			card_data_bus_out <= '0;
			card_data_bus_oe_out <= 1'b0;
			card_rdata_out <= '0;
			attr_select_n_out <= 1'b1;
			card_present_out <= 1'b0;
			card_out <= '0;
		end else begin
			card_address_bus_out <= cyc_addr_in;
			card_data_bus_out <= cyc_wdata_in;
			card_data_bus_oe_out <= cyc_write_in & card_in_q & ctrl_q[`CBI_CTRL_SOCK_PWR];
			if (card_in_q && ctrl_q[`CBI_CTRL_SOCK_PWR]) begin
				card_rdata_out <= card_data_bus_in;
			end else begin
				card_rdata_out <= '0;
			end
			attr_select_n_out <= ~(mem_cycle_in & ctrl_q[`CBI_CTRL_ATTR]);
			card_present_out <= card_in_q;
			card_out <= card_d;
		end
	end
endmodule : cbi_top

// [cbi_card_model.sv]
// Behavioural 16-bit card standing in the socket.
`timescale 1ns/1ps
module cbi_card_model (
	input wire logic clk_in,
	input wire logic present_in,
	input wire logic io_in,
	input wire logic ring_in,
	input wire logic lvl_in,
	output logic cd1_n_out,
	output logic cd2_n_out,
	output logic status_change_in_n_out,
	output logic irq_n_out,
	output logic wide_n_out,
	output logic [15:0] data_out
);
	logic [15:0] junk_q = 16'h0;
	// Pulled-up pins read high while the socket is empty.
	assign cd1_n_out = !present_in;
	assign cd2_n_out = !present_in;
	assign status_change_in_n_out = !(present_in && io_in && ring_in);
	assign irq_n_out = !(present_in && lvl_in);
	assign wide_n_out = !(present_in && lvl_in);
	// An empty socket shows a pattern that changes every cycle, never stale data.
	always_ff @(posedge clk_in) begin
		junk_q <= ~junk_q ^ 16'h5A5A;
	end
	assign data_out = present_in ? 16'hA5C3 : junk_q;
endmodule : cbi_card_model

// [cbi_top_checker.sv]
// Concurrent checks on the card bridge interrupt and socket pin block.
`timescale 1ns/1ps
module cbi_top_checker (
	input wire logic clk_in,
	input wire logic srst_in,
	input wire logic sbus_evt_in,
	input wire logic [2:0] flash_evt_in,
	input wire logic card_detect_first_n_in,
	input wire logic card_detect_second_n_in,
	input wire logic mem_cycle_in,
	input wire logic [25:0] cyc_addr_in,
	input wire logic [25:0] card_address_bus_out,
	input wire logic [15:0] card_rdata_out,
	input wire logic attr_select_n_out,
	input wire logic card_present_out,
	input wire logic socket_irq_line_out,
	input wire logic serial_bus_irq_line_out,
	input wire logic serial_bus_irq_line_oe_out,
	input wire logic flash_media_irq_line_out,
	input wire logic flash_media_irq_line_oe_out,
	input wire logic ring_forward_out
);
	default clocking @(posedge clk_in);
	endclocking
	default disable iff (srst_in);
	// Open-drain pins may only pull low, so their data value stays low.
	a_od_low_only: assert property (
		!(socket_irq_line_out | serial_bus_irq_line_out | flash_media_irq_line_out | ring_forward_out))
		else $error("open-drain pin driven high");
	// Function events pull their own line within two cycles.
	a_sbus_line_pull: assert property (sbus_evt_in |-> ##[1:2] serial_bus_irq_line_oe_out)
		else $error("serial bus line not pulled");
	a_flash_line_pull: assert property (|flash_evt_in |-> ##[1:2] flash_media_irq_line_oe_out)
		else $error("flash media line not pulled");
	// The card address follows the cycle address one cycle later.
	a_addr_follow: assert property (1'b1 |=> card_address_bus_out == $past(cyc_addr_in))
		else $error("card address mismatch");
	// No card means the data input path reads zero.
	a_buf_gated: assert property (!card_present_out [*2] |-> $past(card_rdata_out) == 16'h0)
		else $error("card data not gated");
	// Outside memory cycles the attribute select rests high.
	a_attr_idle: assert property (!mem_cycle_in |=> attr_select_n_out)
		else $error("attribute select low outside memory cycle");
	// Card presence tracks the two detect pins through the synchroniser.
	a_present_off: assert property (card_detect_first_n_in [*5] |-> !card_present_out)
		else $error("card present with detect high");
	a_present_on: assert property (
		(!card_detect_first_n_in && !card_detect_second_n_in) [*5] |-> card_present_out)
		else $error("card absent with both detects low");
endmodule : cbi_top_checker
bind cbi_top cbi_top_checker i_chk (.*);

// [cbi_top_test.sv]
// Self-checking bench for the card bridge interrupt and socket pin block.
`timescale 1ns/1ps
`include "cbi_consts.svh"
module cbi_top_test
	import cbi_pkg::*;
;
	logic clk_in, srst_in, sock_evt_in, sbus_evt_in, mem_cycle_in, cyc_write_in, irq_out;
	cbi_bus_s bus_in;
	cbi_card_s card_out;
	logic [31:0] rdata_out;
	logic [2:0] flash_evt_in;
	logic card_detect_first_n_in, card_detect_second_n_in, status_change_n_in, card_irq_n_in;
	logic wide_io_port_n_in, card_data_bus_oe_out, attr_select_n_out, card_present_out;
	logic [25:0] cyc_addr_in, card_address_bus_out;
	logic [15:0] cyc_wdata_in, card_data_bus_in, card_data_bus_out, card_rdata_out;
	logic socket_irq_line_out, socket_irq_line_oe_out, serial_bus_irq_line_out;
	logic serial_bus_irq_line_oe_out, flash_media_irq_line_out, flash_media_irq_line_oe_out;
	logic ring_forward_out, ring_forward_oe_out, present, io, ring, lvl;
	logic [5:0] user_pin_in, user_pin_out, user_pin_oe_out;
	int miscompares = 0;
	int check_count = 0;
	wire [4:0] watch = {irq_out, ring_forward_oe_out, flash_media_irq_line_oe_out,
		serial_bus_irq_line_oe_out, socket_irq_line_oe_out};
	cbi_top #(.NPINS(6)) i_dut (.*);
	cbi_card_model i_card (.clk_in(clk_in), .present_in(present), .io_in(io), .ring_in(ring),
		.lvl_in(lvl), .cd1_n_out(card_detect_first_n_in), .cd2_n_out(card_detect_second_n_in),
		.status_change_in_n_out(status_change_n_in), .irq_n_out(card_irq_n_in),
		.wide_n_out(wide_io_port_n_in), .data_out(card_data_bus_in));
	// The clock runs at 10 MHz.
	initial begin
		clk_in = 1'b0;
		forever #50 clk_in = ~clk_in;
	end
	task automatic stop_test();
		if (miscompares == 0 && check_count > 0) begin
			$display("Run complete: PASS");
		end else begin
			$display("Run complete: FAIL");
		end
		$finish;
	endtask : stop_test
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		check_count++;
		if (got !== exp) begin
			miscompares++;
			$display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : chk
	// Bus cycles leave one idle edge so no strobe is driven twice in one step.
	task automatic wr(input logic [3:0] a, input logic [31:0] d);
		bus_in <= '{a, d, 1'b1, 1'b0};
		@(posedge clk_in);
		bus_in <= '{a, d, 1'b0, 1'b0};
		@(posedge clk_in);
	endtask : wr
	task automatic rd(input logic [3:0] a, input logic [31:0] m, input logic [31:0] e);
		bus_in <= '{a, 32'h0, 1'b0, 1'b1};
		@(posedge clk_in);
		bus_in <= '{a, 32'h0, 1'b0, 1'b0};
		@(negedge clk_in);
		chk(rdata_out & m, e);
		@(posedge clk_in);
	endtask : rd
	task automatic settle();
		repeat (4) @(posedge clk_in);
		@(negedge clk_in);
	endtask : settle
	// Waits a bounded time for a watched output; running out ends the run.
	task automatic wt(input int b);
		repeat (20) begin
			@(negedge clk_in);
			if (watch[b] === 1'b1) begin
				@(posedge clk_in);
				return;
			end
		end
		miscompares++;
		stop_test();
	endtask : wt
	task automatic pk(input int b, input logic e);
		settle();
		chk(watch[b], e);
		@(posedge clk_in);
	endtask : pk
	// Main sequence of register calls and pin stimulus.
	initial begin
		srst_in = 1'b1;
		bus_in = '0;
		{sock_evt_in, sbus_evt_in, mem_cycle_in, cyc_write_in} = 4'h0;
		flash_evt_in = 3'h0;
		cyc_addr_in = 26'h0;
		cyc_wdata_in = 16'h0;
		user_pin_in = 6'h2A;
		{present, io, ring, lvl} = 4'h0;
		repeat (6) @(posedge clk_in);
		srst_in <= 1'b0;
		@(posedge clk_in);
		rd(`CBI_OFF_CTRL, 32'hFFFFFFFF, `CBI_CTRL_RESET);
		rd(`CBI_OFF_PINFN, 32'hFFFFFFFF, `CBI_PINFN_RESET);
		rd(4'hF, 32'hFFFFFFFF, 32'h0);
		wr(`CBI_OFF_STATUS, 32'h1F);
		wr(`CBI_OFF_MASK, 32'h2);
		sbus_evt_in <= 1'b1;
		wt(1);
		sbus_evt_in <= 1'b0;
		wt(4);
		rd(`CBI_OFF_STATUS, 32'h7, 32'h2);
		wr(`CBI_OFF_STATUS, 32'h2);
		pk(4, 1'b0);
		for (int i = 0; i < 3; i++) begin
			flash_evt_in <= 3'(3'h1 << i);
			wt(2);
			flash_evt_in <= 3'h0;
			pk(4, 1'b0);
			wr(`CBI_OFF_STATUS, 32'h4);
			pk(2, 1'b0);
		end
		sock_evt_in <= 1'b1;
		wt(0);
		sock_evt_in <= 1'b0;
		wr(`CBI_OFF_STATUS, 32'h1F);
		pk(0, 1'b0);
		wr(`CBI_OFF_CTRL, 32'h81);
		sock_evt_in <= 1'b1;
		pk(0, 1'b0);
		sock_evt_in <= 1'b0;
		{present, io, lvl} <= 3'h7;
		wt(0);
		settle();
		chk({card_out.card_irq, card_out.wide_port}, 2'h3);
		@(posedge clk_in);
		rd(`CBI_OFF_PINS, 32'h40, 32'h40);
		// Memory card: ready level, attribute select, data gating and address.
		{io, lvl, mem_cycle_in, cyc_write_in} <= 4'h3;
		cyc_wdata_in <= 16'h5A3C;
		cyc_addr_in <= 26'h3FFFFFF;
		wr(`CBI_OFF_CTRL, 32'h0);
		settle();
		chk({card_out.ready, card_out.write_protect}, 2'h3);
		chk(attr_select_n_out, 1'b1);
		chk(card_rdata_out, 16'h0);
		chk(card_address_bus_out, 26'h3FFFFFF);
		@(posedge clk_in);
		wr(`CBI_OFF_CTRL, 32'h140);
		settle();
		chk({attr_select_n_out, card_data_bus_oe_out}, 2'h1);
		chk(card_data_bus_out, 16'h5A3C);
		chk(card_rdata_out, 16'hA5C3);
		@(posedge clk_in);
		present <= 1'b0;
		settle();
		chk({card_rdata_out, card_data_bus_oe_out}, 17'h0);
		@(posedge clk_in);
		rd(`CBI_OFF_PINS, 32'h40, 32'h0);
		// Ring forwarding, its enable, then both ways into wake mode.
		{present, io, mem_cycle_in} <= 3'h6;
		wr(`CBI_OFF_CTRL, 32'hC4);
		ring <= 1'b1;
		wt(3);
		ring <= 1'b0;
		pk(3, 1'b0);
		wr(`CBI_OFF_CTRL, 32'hC0);
		ring <= 1'b1;
		pk(3, 1'b0);
		ring <= 1'b0;
		for (int i = 0; i < 2; i++) begin
			wr(`CBI_OFF_CTRL, i ? 32'hD0 : 32'hC8);
			// Clear twice so a ring still draining the synchroniser cannot leave wake set.
			repeat (2) wr(`CBI_OFF_STATUS, 32'h1F);
			pk(3, 1'b0);
			ring <= 1'b1;
			wt(3);
			ring <= 1'b0;
			rd(`CBI_OFF_STATUS, 32'h10, 32'h10);
		end
		// Socket line sourced from the card change status bit on removal.
		wr(`CBI_OFF_CTRL, 32'h3);
		wr(`CBI_OFF_STATUS, 32'h1F);
		present <= 1'b0;
		wt(0);
		wr(`CBI_OFF_STATUS, 32'h8);
		pk(0, 1'b0);
		wr(`CBI_OFF_PINFN, 32'h39);
		wr(`CBI_OFF_GPIO_OUT, 32'h3);
		settle();
		chk({user_pin_oe_out[3:0], user_pin_out[2:0]}, 7'h3D);
		@(posedge clk_in);
		rd(`CBI_OFF_GPIO_IN, 32'h3F, 32'h2A);
		stop_test();
	end
endmodule : cbi_top_test
